// ---- bench/gsr_host.sv ----
// gsr_host: host model issuing byte accesses and commands
// assumes: bank takes req on rising clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module gsr_host (
  // clock
  input  wire logic             clk_sys_i,
  // request to bank
  output var gsr_pkg::gsr_req_t req_o
);
  initial req_o = '0;
  ////////////////////////////////////////////////////////////////
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 req_o = {w, r, a, d};
    @(posedge clk_sys_i);
    #1 req_o = '0;
  endtask : acc
  // mode first, then key, then idle
  task automatic cmd(input logic [7:0] m);
    acc(1'b1, 1'b0, gsr_pkg::ADDR_MODE, m);
    acc(1'b1, 1'b0, gsr_pkg::ADDR_CTRL, gsr_pkg::CMD_KEY);
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : cmd
  // board offset from the two offset results, for the pack config byte
  function automatic logic [15:0] board_offset(input logic [15:0] ext, input logic [15:0] intl);
    return ext - intl;
  endfunction : board_offset
endmodule : gsr_host
`default_nettype wire

// ---- bench/test_gsr_bank.sv ----
// test_gsr_bank: self-checking bench of the register bank
// assumes: host model drives the port, bench drives engine inputs
`timescale 1ns/10ps
`default_nettype none
module test_gsr_bank;
  logic clk_sys_i, reset_n_i, rd_valid_o, partial_reset_o, full_reset_o, ship_request_o;
  logic avg_update_i, taper_cond_i, charging_i, below_dmf_i, cal_active_i, learn_ok_i;
  logic learn_disq_i, empty_reached_i, charge_tick_i, discharge_tick_i, cycle_inc_i;
  logic soft_reset_i, ram_corrupt_i;
  logic [7:0] rd_data_o;
  logic [7:0] expq[$];
  logic [15:0] die_temp_i, cell_voltage_pin_i, rate_predicted_capacity_i, average_current_i;
  logic [15:0] first_empty_mv_i, final_empty_mv_i, discharged_cap_i, design_cap_i, rate;
  logic [15:0] host_rate_value_o, nominal_capacity_o, learned_full_capacity_o;
  logic [31:0] seed, rt;
  gsr_pkg::gsr_req_t req_i;
  gsr_pkg::gsr_flags_t flags_o;
  int fails, samples_checked, cycles;
  gsr_bank #(.REFRESH_CYCLES(50)) u_gsr_bank (.*);
  gsr_host u_gsr_host (.clk_sys_i(clk_sys_i), .req_o(req_i));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_gsr_host.acc(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic put_rate;
    u_gsr_host.acc(1'b1, 1'b0, gsr_pkg::ADDR_RATE_LO, rate[7:0]);
    u_gsr_host.acc(1'b1, 1'b0, gsr_pkg::ADDR_RATE_HI, rate[15:8]);
  endtask : put_rate
  task automatic conclude;
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task automatic tick(input logic up);
    @(posedge clk_sys_i);
    #1 {charge_tick_i, discharge_tick_i} = {up, ~up};
    @(posedge clk_sys_i);
    #1 {charge_tick_i, discharge_tick_i} = 2'b00;
  endtask : tick
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    if (rd_valid_o === 1'b1) begin
      check({8'h00, rd_data_o}, {8'h00, expq.pop_front()});
    end
    cycles++;
    if (cycles == 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {avg_update_i, taper_cond_i, charging_i, below_dmf_i, cal_active_i, learn_ok_i} = '0;
    {learn_disq_i, empty_reached_i, charge_tick_i, discharge_tick_i, cycle_inc_i} = '0;
    {soft_reset_i, ram_corrupt_i, average_current_i} = '0;
    {first_empty_mv_i, final_empty_mv_i, discharged_cap_i} = '0;
    {die_temp_i, cell_voltage_pin_i, design_cap_i} = {16'h0C01, 16'h1770, 16'h1234};
    rate_predicted_capacity_i = 16'h4000;
    seed = 32'hDEDB;
    reset_n_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    check({8'h00, flags_o}, 16'h0010);
    rd(gsr_pkg::ADDR_FLAGS, 8'h12);
    rd(8'h40, 8'h00);
    seed = xs(seed);
    rate = {1'b0, seed[14:0]};
    put_rate();
    u_gsr_host.acc(1'b1, 1'b0, gsr_pkg::ADDR_FLAGS, 8'hFF);
    rd(gsr_pkg::ADDR_RATE_HI, rate[15:8]);
    rd(gsr_pkg::ADDR_FLAGS, 8'h12);
    check(host_rate_value_o, rate);
    $display("test access done");
    u_gsr_host.cmd(8'h3A);
    check(nominal_capacity_o, rate);
    rd(gsr_pkg::ADDR_MODE, 8'h00);
    rd(gsr_pkg::ADDR_CTRL, 8'h00);
    u_gsr_host.cmd(8'h02);
    check(learned_full_capacity_o, design_cap_i);
    {charging_i, below_dmf_i} = 2'b11;
    rd(gsr_pkg::ADDR_FLAGS, 8'hD2);
    put_rate();
    u_gsr_host.cmd(8'h20);
    u_gsr_host.cmd(8'h08);
    check(nominal_capacity_o, rate);
    put_rate();
    $display("test commands done");
    repeat (60) @(posedge clk_sys_i);
    rd(gsr_pkg::ADDR_VOLTAGE_PAIR_LO, 8'h88);
    rd(gsr_pkg::ADDR_VOLTAGE_PAIR_HI, 8'h13);
    rd(gsr_pkg::ADDR_TEMP_HI, 8'h0C);
    repeat (3) tick(1'b1);
    tick(1'b0);
    @(posedge clk_sys_i);
    #1 check(nominal_capacity_o, rate + 16'h0002);
    repeat (40) @(posedge clk_sys_i);
    rt = (32'h0000_4000 * 32'h0000_003C) / {16'h0000, rate};
    rd(gsr_pkg::ADDR_RTTE_LO, rt[7:0]);
    rd(gsr_pkg::ADDR_RTTE_HI, rt[15:8]);
    rd(gsr_pkg::ADDR_REL_CHG, 8'h64);
    $display("test measure done");
    {learn_ok_i, discharged_cap_i} = {1'b1, seed[31:16]};
    u_gsr_host.cmd(8'h02);
    first_empty_mv_i = 16'h1400;
    @(posedge clk_sys_i);
    #1 check(learned_full_capacity_o, discharged_cap_i);
    check({15'h0000, flags_o.learn_stale_flag}, 16'h0000);
    $display("test learn done");
    conclude();
  end
endmodule : test_gsr_bank
`default_nettype wire

// ---- common/gsr_pkg.sv ----
// gsr_pkg: constants and types for the gauge status register bank
// assumes: one 50 MHz system clock, byte-wide register access port
package gsr_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_MODE      = 8'h01;
  localparam logic [7:0] ADDR_RATE_LO   = 8'h02;
  localparam logic [7:0] ADDR_RATE_HI   = 8'h03;
  localparam logic [7:0] ADDR_RTTE_LO   = 8'h04;
  localparam logic [7:0] ADDR_RTTE_HI   = 8'h05;
  localparam logic [7:0] ADDR_TEMP_LO   = 8'h06;
  localparam logic [7:0] ADDR_TEMP_HI   = 8'h07;
  localparam logic [7:0] ADDR_VOLTAGE_PAIR_LO   = 8'h08;
  localparam logic [7:0] ADDR_VOLTAGE_PAIR_HI   = 8'h09;
  localparam logic [7:0] ADDR_FLAGS     = 8'h0A;
  localparam logic [7:0] ADDR_REL_CHG   = 8'h0B;
  localparam logic [7:0] ADDR_NOMCAP_LO = 8'h0C;
  localparam logic [7:0] ADDR_NOMCAP_HI = 8'h0D;

  // command key and mode bit positions
  localparam logic [7:0] CMD_KEY        = 8'hA9;
  localparam int         MODE_LOAD_BIT  = 5;
  localparam int         MODE_FULL_BIT  = 4;
  localparam int         MODE_PART_BIT  = 3;
  localparam int         MODE_PWRON_BIT = 2;
  localparam int         MODE_FRESET_BIT = 1;
  localparam int         MODE_SHIP_BIT  = 0;
  localparam logic [7:0] MODE_CMD_MASK  = 8'h3B;
  localparam logic [7:0] MODE_RESET     = 8'hC4;

  // reset values
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] RATE_RESET    = 16'h0000;
  localparam logic [15:0] NOMCAP_RESET  = 16'h0000;
  localparam logic [15:0] LEARNED_RESET = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET   = 8'h10;

  // arithmetic constants
  localparam logic [15:0] VOLTAGE_PAIR_MAX_MV      = 16'd5000;
  localparam logic [5:0]  STALE_CYCLES     = 6'd32;
  localparam logic [2:0]  TAPER_SAMPLES    = 3'd4;
  localparam logic [15:0] TAPER_MIN_CUR    = 16'd8;
  localparam logic [15:0] MINUTES_PER_HOUR = 16'd60;
  localparam logic [15:0] PERCENT_FULL     = 16'd100;
  localparam int          PCT_SHIFT        = 4;

  // refresh period of temperature and voltage
  localparam int CLK_HZ          = 50_000_000;
  localparam int REFRESH_MS      = 2560;
  localparam int REFRESH_CYCLES  = REFRESH_MS * (CLK_HZ / 1000);

  // status byte, bit 7 first
  typedef struct packed {
    logic charging_state_flag;
    logic idle_sense_flag;
    logic taper_detect_flag;
    logic learn_stale_flag;
    logic offset_cal_busy_flag;
    logic learn_qualified_flag;
    logic first_empty_voltage_flag;
    logic final_empty_flag;
  } gsr_flags_t;

  // host register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gsr_req_t;

  typedef enum logic {DIV_REL_CHARGE, DIV_RUNTIME} gsr_div_sel_t;

endpackage : gsr_pkg

// ---- design/gsr_bank.sv ----
// gsr_bank: host visible register bank of a single cell capacity gauge
// assumes: byte register port from the serial front end, measurement engine inputs
//
// Overview of operation
// (R1) mode bits ranked load, full, partial, reset
// (R2) key 0xA9 runs top bit, then clears
// (R3) host writes mode first, then the key
// (R4) rate value feeds prediction path only; the load command also copies it to nominal capacity
// (R5) rate value always taken as discharge
// (R6) rate value seeds nominal capacity in manufacture
// (R7) runtime is 60 times predicted capacity per rate
// (R8) temperature pair read only, refreshed 2.56 s
// (R9) voltage pair read only, clamped 5000 mV
// (R10) stale flag cleared on learn, set on full reset
// (R11) stale flag set after 32 cycle increments
// (R12) idle flag follows sense threshold, reset clears
// (R13) calibration busy during offset measurement
// (R14) qualified flag set on requirements, cleared on reset, learn or disqualify
// (R15) first empty flag, learn on rising edge
// (R16) final empty flag at empty threshold
// (R17) relative charge is 100 times nominal per learned
// (R18) nominal counts up above empty, down discharging
// (R19) nominal cleared on reset only if corrupt
// (R20) host derives board offset from two measurements
// (R21) load copies rate, set full copies learned
// (R22) partial keeps capacities and stale, full clears nominal, learned takes design, stale set
// (R23) status byte layout, only stale after power-on
// (R24) taper needs four samples, current at least 8
// (R25) low byte at lower address, high next
`timescale 1ns/10ps
`default_nettype none
module gsr_bank #(
  parameter int REFRESH_CYCLES = gsr_pkg::REFRESH_CYCLES
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  // host register port
  input  wire gsr_pkg::gsr_req_t req_i,
  output logic            [7:0]  rd_data_o,
  output logic                   rd_valid_o,
  // measurement engine
  input  wire logic       [15:0] die_temp_i,
  input  wire logic       [15:0] cell_voltage_pin_i,
  input  wire logic       [15:0] rate_predicted_capacity_i,
  input  wire logic       [15:0] average_current_i,
  input  wire logic              avg_update_i,
  input  wire logic              taper_cond_i,
  input  wire logic              charging_i,
  input  wire logic              below_dmf_i,
  input  wire logic              cal_active_i,
  input  wire logic              learn_ok_i,
  input  wire logic              learn_disq_i,
  input  wire logic              empty_reached_i,
  input  wire logic       [15:0] first_empty_mv_i,
  input  wire logic       [15:0] final_empty_mv_i,
  input  wire logic       [15:0] discharged_cap_i,
  input  wire logic       [15:0] design_cap_i,
  input  wire logic              charge_tick_i,
  input  wire logic              discharge_tick_i,
  input  wire logic              cycle_inc_i,
  // device resets
  input  wire logic              soft_reset_i,
  input  wire logic              ram_corrupt_i,
  // results to the rest of the gauge
  output logic            [15:0] host_rate_value_o,
  output logic            [15:0] nominal_capacity_o,
  output logic            [15:0] learned_full_capacity_o,
  output gsr_pkg::gsr_flags_t    flags_o,
  output logic                   partial_reset_o,
  output logic                   full_reset_o,
  output logic                   ship_request_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]          ctrl_reg;
  logic [7:0]          mode_reg;
  logic                cmd_go_reg;
  logic [15:0]         rate_reg;
  logic [15:0]         runtime_reg;
  logic [15:0]         temp_reg;
  logic [15:0]         voltage_pair_reg;
  logic [7:0]          rel_chg_reg;
  logic [15:0]         nomcap_reg;
  logic [15:0]         learned_reg;
  gsr_pkg::gsr_flags_t flags_reg;
  logic [5:0]          cyc_cnt_reg;
  logic [2:0]          taper_cnt_reg;
  logic [31:0]         tick_cnt_reg;
  logic                refresh_tick;
  logic                do_load;
  logic                do_full_cap;
  logic                do_partial;
  logic                do_freset;
  logic                do_ship;
  logic                any_reset;
  logic                wipe_ram;
  logic                first_empty_voltage_flag_cond;
  logic                learn_update;
  gsr_pkg::gsr_div_sel_t div_sel_reg;
  logic                div_start;
  logic                div_busy;
  logic                div_done;
  logic [15:0]         div_quot;
  logic [31:0]         div_num;
  logic [15:0]         div_den;

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  always_comb begin
    do_load     = 1'b0;
    do_full_cap = 1'b0;
    do_partial  = 1'b0;
    do_freset   = 1'b0;
    do_ship     = 1'b0;
    if (cmd_go_reg) begin
      if (mode_reg[gsr_pkg::MODE_LOAD_BIT]) begin // R1
        do_load = 1'b1;
      end else if (mode_reg[gsr_pkg::MODE_FULL_BIT]) begin
        do_full_cap = 1'b1;
      end else if (mode_reg[gsr_pkg::MODE_PART_BIT]) begin
        do_partial = 1'b1;
      end else if (mode_reg[gsr_pkg::MODE_FRESET_BIT]) begin
        do_freset = 1'b1;
      end else begin
        do_ship = mode_reg[gsr_pkg::MODE_SHIP_BIT];
      end
    end
  end

  assign any_reset       = do_partial | do_freset | soft_reset_i;
  assign wipe_ram        = do_freset | (soft_reset_i & ram_corrupt_i);
  assign partial_reset_o = do_partial;
  assign full_reset_o    = do_freset;
  assign ship_request_o  = do_ship;

  // key write arms one execution; key and mode command bits cleared afterwards
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg   <= gsr_pkg::CTRL_RESET;
      mode_reg   <= gsr_pkg::MODE_RESET;
      cmd_go_reg <= 1'b0;
    end else if (cmd_go_reg) begin
      ctrl_reg   <= gsr_pkg::CTRL_RESET; // R2
      mode_reg   <= mode_reg & ~gsr_pkg::MODE_CMD_MASK; // R2
      cmd_go_reg <= 1'b0;
    end else if (req_i.wr && req_i.addr == gsr_pkg::ADDR_CTRL) begin
      ctrl_reg   <= req_i.wdata;
      cmd_go_reg <= (req_i.wdata == gsr_pkg::CMD_KEY); // R3
    end else if (req_i.wr && req_i.addr == gsr_pkg::ADDR_MODE) begin
      mode_reg   <= req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate register, host writable, low byte at the lower address
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_reg <= gsr_pkg::RATE_RESET;
    end else if (any_reset) begin
      rate_reg <= gsr_pkg::RATE_RESET;
    end else if (req_i.wr && req_i.addr == gsr_pkg::ADDR_RATE_LO) begin
      rate_reg[7:0] <= req_i.wdata; // R25
    end else if (req_i.wr && req_i.addr == gsr_pkg::ADDR_RATE_HI) begin
      rate_reg[15:8] <= req_i.wdata; // R25
    end
  end

  // unsigned magnitude to the prediction path; load also copies rate_reg to nominal capacity
  assign host_rate_value_o = rate_reg; // R4 R5

  ////////////////////////////////////////////////////////////////////////////
  // 2.56 s refresh of temperature and voltage
  assign refresh_tick = (tick_cnt_reg == 32'(REFRESH_CYCLES - 1));

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (refresh_tick) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_reg <= 16'h0000;
      voltage_pair_reg <= 16'h0000;
    end else if (refresh_tick) begin
      temp_reg <= die_temp_i; // R8
      if (cell_voltage_pin_i > gsr_pkg::VOLTAGE_PAIR_MAX_MV) begin
        voltage_pair_reg <= gsr_pkg::VOLTAGE_PAIR_MAX_MV; // R9
      end else begin
        voltage_pair_reg <= cell_voltage_pin_i; // R9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nominal and learned capacity
  assign first_empty_voltage_flag_cond = (voltage_pair_reg <= first_empty_mv_i) &&
                     (nomcap_reg <= (learned_reg >> gsr_pkg::PCT_SHIFT));
  assign learn_update = first_empty_voltage_flag_cond && !flags_reg.first_empty_voltage_flag &&
                        flags_reg.learn_qualified_flag; // R15

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nomcap_reg <= gsr_pkg::NOMCAP_RESET;
    end else if (wipe_ram) begin
      nomcap_reg <= gsr_pkg::NOMCAP_RESET; // R19 R22
    end else if (do_load) begin
      nomcap_reg <= rate_reg; // R6 R21
    end else if (do_full_cap) begin
      nomcap_reg <= learned_reg; // R21
    end else if (charge_tick_i && !discharge_tick_i) begin
      if (voltage_pair_reg > final_empty_mv_i && nomcap_reg != 16'hFFFF) begin
        nomcap_reg <= nomcap_reg + 16'h0001; // R18
      end
    end else if (discharge_tick_i && !charge_tick_i && nomcap_reg != 16'h0000) begin
      nomcap_reg <= nomcap_reg - 16'h0001; // R18
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      learned_reg <= gsr_pkg::LEARNED_RESET;
    end else if (wipe_ram) begin
      learned_reg <= design_cap_i; // R22
    end else if (learn_update) begin
      learned_reg <= discharged_cap_i; // R15
    end
  end

  assign nominal_capacity_o      = nomcap_reg;
  assign learned_full_capacity_o = learned_reg;

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cyc_cnt_reg <= 6'h00;
    end else if (wipe_ram || learn_update) begin
      cyc_cnt_reg <= 6'h00;
    end else if (cycle_inc_i && cyc_cnt_reg != gsr_pkg::STALE_CYCLES) begin
      cyc_cnt_reg <= cyc_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_reg.learn_stale_flag <= gsr_pkg::FLAGS_RESET[4]; // R23
    end else if (wipe_ram || cyc_cnt_reg == gsr_pkg::STALE_CYCLES) begin
      flags_reg.learn_stale_flag <= 1'b1; // R10 R11
    end else if (learn_update) begin
      flags_reg.learn_stale_flag <= 1'b0; // R10
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      taper_cnt_reg <= 3'h0;
    end else if (any_reset) begin
      taper_cnt_reg <= 3'h0;
    end else if (avg_update_i) begin
      if (average_current_i < gsr_pkg::TAPER_MIN_CUR || !taper_cond_i) begin
        taper_cnt_reg <= 3'h0; // R24
      end else if (taper_cnt_reg != gsr_pkg::TAPER_SAMPLES) begin
        taper_cnt_reg <= taper_cnt_reg + 3'h1; // R24
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_reg.learn_qualified_flag <= 1'b0;
    end else if (learn_ok_i && !any_reset && !learn_update && !learn_disq_i) begin
      flags_reg.learn_qualified_flag <= 1'b1; // R14
    end else if (any_reset || learn_update || learn_disq_i) begin
      flags_reg.learn_qualified_flag <= 1'b0; // R14
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_reg.charging_state_flag      <= 1'b0;
      flags_reg.idle_sense_flag          <= 1'b0;
      flags_reg.taper_detect_flag        <= 1'b0;
      flags_reg.offset_cal_busy_flag     <= 1'b0;
      flags_reg.first_empty_voltage_flag <= 1'b0;
      flags_reg.final_empty_flag         <= 1'b0;
    end else if (any_reset) begin
      flags_reg.charging_state_flag      <= 1'b0;
      flags_reg.idle_sense_flag          <= 1'b0; // R12
      flags_reg.taper_detect_flag        <= 1'b0;
      flags_reg.offset_cal_busy_flag     <= 1'b0; // R13
      flags_reg.first_empty_voltage_flag <= 1'b0;
      flags_reg.final_empty_flag         <= 1'b0; // R16
    end else begin
      flags_reg.charging_state_flag      <= charging_i;
      flags_reg.idle_sense_flag          <= below_dmf_i; // R12
      flags_reg.taper_detect_flag        <= (taper_cnt_reg == gsr_pkg::TAPER_SAMPLES); // R24
      flags_reg.offset_cal_busy_flag     <= cal_active_i; // R13
      flags_reg.first_empty_voltage_flag <= first_empty_voltage_flag_cond; // R15
      flags_reg.final_empty_flag         <= empty_reached_i; // R16
    end
  end

  assign flags_o = flags_reg;

  ////////////////////////////////////////////////////////////////////////////
  // shared divider for relative charge and predicted runtime
  assign div_start = !div_busy && !div_done;
  assign div_num   = (div_sel_reg == gsr_pkg::DIV_REL_CHARGE) ?
                     (nomcap_reg * gsr_pkg::PERCENT_FULL) : // R17
                     (rate_predicted_capacity_i * gsr_pkg::MINUTES_PER_HOUR); // R7
  assign div_den   = (div_sel_reg == gsr_pkg::DIV_REL_CHARGE) ? learned_reg : rate_reg;

  gsr_divider u_div (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .start_i    (div_start),
    .dividend_i (div_num),
    .divisor_i  (div_den),
    .busy_o     (div_busy),
    .done_o     (div_done),
    .quot_o     (div_quot)
  );

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_sel_reg <= gsr_pkg::DIV_REL_CHARGE;
      rel_chg_reg <= 8'h00;
      runtime_reg <= 16'h0000;
    end else if (div_done) begin
      if (div_sel_reg == gsr_pkg::DIV_REL_CHARGE) begin
        rel_chg_reg <= (div_quot > gsr_pkg::PERCENT_FULL) ? 8'h64 : div_quot[7:0]; // R17
        div_sel_reg <= gsr_pkg::DIV_RUNTIME;
      end else begin
        runtime_reg <= div_quot; // R7
        div_sel_reg <= gsr_pkg::DIV_REL_CHARGE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, one cycle latency, unmapped reads zero
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
      if (req_i.rd) begin
        unique case (req_i.addr)
          gsr_pkg::ADDR_CTRL:      rd_data_o <= ctrl_reg;
          gsr_pkg::ADDR_MODE:      rd_data_o <= mode_reg;
          gsr_pkg::ADDR_RATE_LO:   rd_data_o <= rate_reg[7:0];
          gsr_pkg::ADDR_RATE_HI:   rd_data_o <= rate_reg[15:8];
          gsr_pkg::ADDR_RTTE_LO:   rd_data_o <= runtime_reg[7:0];
          gsr_pkg::ADDR_RTTE_HI:   rd_data_o <= runtime_reg[15:8];
          gsr_pkg::ADDR_TEMP_LO:   rd_data_o <= temp_reg[7:0]; // R25
          gsr_pkg::ADDR_TEMP_HI:   rd_data_o <= temp_reg[15:8];
          gsr_pkg::ADDR_VOLTAGE_PAIR_LO:   rd_data_o <= voltage_pair_reg[7:0];
          gsr_pkg::ADDR_VOLTAGE_PAIR_HI:   rd_data_o <= voltage_pair_reg[15:8];
          gsr_pkg::ADDR_FLAGS:     rd_data_o <= flags_reg; // R23
          gsr_pkg::ADDR_REL_CHG:   rd_data_o <= rel_chg_reg;
          gsr_pkg::ADDR_NOMCAP_LO: rd_data_o <= nomcap_reg[7:0];
          gsr_pkg::ADDR_NOMCAP_HI: rd_data_o <= nomcap_reg[15:8];
          default:                 rd_data_o <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_key_armed;
    cmd_go_reg && mode_reg[gsr_pkg::MODE_LOAD_BIT];
  endsequence

  a_key_clears_ctrl: assert property ( // R2
    cmd_go_reg |=> (ctrl_reg == 8'h00) && ((mode_reg & gsr_pkg::MODE_CMD_MASK) == 8'h00))
    else $error("key register or mode bits not cleared");

  a_load_wins_prio: assert property ( // R1
    s_key_armed |-> !do_full_cap && !do_partial && !do_freset && !do_ship)
    else $error("lower command ran beside load");

  a_load_copies_rate: assert property ( // R21
    (s_key_armed and !soft_reset_i) |=> nomcap_reg == $past(rate_reg))
    else $error("load did not copy rate value");

  a_partial_keeps_cap: assert property ( // R22
    do_partial && !soft_reset_i |=> nomcap_reg == $past(nomcap_reg) &&
      learned_reg == $past(learned_reg))
    else $error("partial reset changed capacity");

  a_full_sets_stale: assert property ( // R10
    do_freset |=> flags_reg.learn_stale_flag && nomcap_reg == 16'h0000)
    else $error("full reset did not mark stale");

  a_voltage_pair_clamp_max: assert property ( // R9
    voltage_pair_reg <= gsr_pkg::VOLTAGE_PAIR_MAX_MV)
    else $error("voltage above clamp");

  a_stale_after_32: assert property ( // R11
    cyc_cnt_reg == gsr_pkg::STALE_CYCLES |=> flags_reg.learn_stale_flag)
    else $error("stale flag missing after 32 cycles");

  a_taper_low_cur: assert property ( // R24
    avg_update_i && average_current_i < gsr_pkg::TAPER_MIN_CUR && !any_reset
      |=> ##1 !flags_reg.taper_detect_flag)
    else $error("taper flag with low current");

  a_idle_reset_clr: assert property ( // R12
    any_reset |=> !flags_reg.idle_sense_flag && !flags_reg.offset_cal_busy_flag)
    else $error("flags not cleared on reset");

  a_rel_chg_max: assert property ( // R17
    rel_chg_reg <= 8'd100)
    else $error("relative charge above full");

  a_learn_on_edge: assert property ( // R15
    learn_update && !wipe_ram |=> learned_reg == $past(discharged_cap_i) &&
      !flags_reg.learn_qualified_flag)
    else $error("learned capacity not updated");

endmodule : gsr_bank
`default_nettype wire

// ---- design/gsr_divider.sv ----
// gsr_divider: iterative unsigned divider, 32 by 16 bits, one bit per cycle
// assumes: start only while idle; quotient saturates to 16 bits
`timescale 1ns/10ps
`default_nettype none
module gsr_divider (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // request
  input  wire logic        start_i,
  input  wire logic [31:0] dividend_i,
  input  wire logic [15:0] divisor_i,
  // answer
  output logic             busy_o,
  output logic             done_o,
  output logic      [15:0] quot_o
);

  logic [31:0] quot_reg;
  logic [32:0] rem_reg;
  logic [15:0] div_reg;
  logic [5:0]  count_reg;
  logic [32:0] trial;

  assign trial  = {rem_reg[31:0], quot_reg[31]} - {17'h00000, div_reg};
  assign busy_o = (count_reg != 6'h00);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quot_reg  <= 32'h00000000;
      rem_reg   <= 33'h000000000;
      div_reg   <= 16'h0000;
      count_reg <= 6'h00;
    end else if (start_i && !busy_o) begin
      quot_reg  <= dividend_i;
      rem_reg   <= 33'h000000000;
      div_reg   <= divisor_i;
      count_reg <= 6'h20;
    end else if (busy_o) begin
      count_reg <= count_reg - 6'h01;
      if (!trial[32]) begin
        rem_reg  <= trial;
        quot_reg <= {quot_reg[30:0], 1'b1};
      end else begin
        rem_reg  <= {rem_reg[31:0], quot_reg[31]};
        quot_reg <= {quot_reg[30:0], 1'b0};
      end
    end
  end

  // result register; zero divisor or overflow saturates
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o <= 1'b0;
      quot_o <= 16'h0000;
    end else begin
      done_o <= (count_reg == 6'h01);
      if (count_reg == 6'h01) begin
        if (div_reg == 16'h0000 || quot_reg[30:15] != 16'h0000) begin
          quot_o <= 16'hFFFF;
        end else begin
          quot_o <= {quot_reg[14:0], ~trial[32]};
        end
      end
    end
  end

endmodule : gsr_divider
`default_nettype wire
